// [hw/pci_window_defs.svh]
// Offsets, field positions, reset values and EEPROM word numbers.
`ifndef PCI_WINDOW_DEFS_SVH
`define PCI_WINDOW_DEFS_SVH

// ----------------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------------
`define IO_WINDOW_BASE_OFS 8'h10
`define MEM_WINDOW_BASE_OFS 8'h14
`define SUBSYS_MAKER_OFS 8'h2c
`define SUBSYS_PRODUCT_OFS 8'h2e

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WINDOW_LSB 7
`define IO_KIND_FLAG_VAL 1'h1
`define MEM_KIND_FLAG_VAL 1'h0
`define PREFETCH_VAL 1'h0
`define PLACE_ANY_32 2'h0
`define PLACE_BELOW_1MB 2'h1
`define OPT_PLACE_BIT 2

// ----------------------------------------------------------------------
// Reset values and EEPROM word numbers
// ----------------------------------------------------------------------
`define WINDOW_RESET 25'h0000000
`define CODE_RESET 16'h0000
`define EE_OPTIONS_WORD 8'h00
`define EE_MAKER_WORD 8'h17
`define EE_PRODUCT_WORD 8'h18

`endif

// [hw/pci_window_pkg.sv]
// Types shared by the window base and subsystem register block.
package pci_window_pkg;

    // ------------------------------------------------------------------
    // Loader states and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LOAD_OPTIONS,
        LOAD_MAKER,
        LOAD_PRODUCT,
        LOAD_DONE
    } load_state_e;

    // Host access presented for window decode.
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [31:0] addr;
    } win_req_s;

    // Decode answer for one access.
    typedef struct packed {
        logic hit;
        logic is_io;
        logic [6:0] offset;
    } win_claim_s;

endpackage : pci_window_pkg

// [hw/pci_window_base_and_subsystem_regs.sv]
// Window base registers, subsystem codes and window decode.
//
// Contract
// - Bit 0 of the I/O window base always reads one and ignores writes.
// - Only the upper 25 bits of the I/O window base are writable.
// - Bits 6 to 2 of the I/O window base always read zero.
// - Bit 1 of the I/O window base always reads zero.
// - Bit 0 of the memory window base always reads zero.
// - Memory base bits 31 to 7 are written, bits 6 to 4 forced zero.
// - Memory base bit 3 always reads zero and is read-only.
// - Memory base bits 2:1 read 00b or 01b from EEPROM option bit 2.
// - Both base registers read as 32 bits but store only bits 31 to 7.
// - The register set is reachable through both windows.
// - After reset the maker code is loaded from EEPROM word 17h.
// - After reset the product code is loaded from EEPROM word 18h.
`timescale 1ns/1ns
`include "pci_window_defs.svh"

module pci_window_base_and_subsystem_regs
    import pci_window_pkg::*;
#(
    parameter int CFG_AW = 8
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Configuration register port
    input wire logic [CFG_AW-1:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [31:0] cfg_rdata,
    // EEPROM word reader
    output logic ee_req,
    output logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic [15:0] ee_data,
    output logic ee_loaded,
    // Window decode
    input win_req_s win_req,
    output win_claim_s win_claim
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // Decoding the offsets below needs at least eight address bits.
    generate
        if (CFG_AW < 8)
        begin : g_bad_aw
            $error("CFG_AW must be at least 8");
        end
    endgenerate

    // Register offsets sized to the configuration address port.
    localparam logic [CFG_AW-1:0] IO_OFS = CFG_AW'(`IO_WINDOW_BASE_OFS);
    localparam logic [CFG_AW-1:0] MEM_OFS = CFG_AW'(`MEM_WINDOW_BASE_OFS);
    localparam logic [CFG_AW-1:0] MAKER_OFS = CFG_AW'(`SUBSYS_MAKER_OFS);
    localparam logic [CFG_AW-1:0] PROD_OFS = CFG_AW'(`SUBSYS_PRODUCT_OFS);

    // ------------------------------------------------------------------
    // Base register state
    // ------------------------------------------------------------------
    logic [24:0] io_window_field_r;
    logic [24:0] io_window_field_nxt;
    logic [24:0] mem_window_field_r;
    logic [24:0] mem_window_field_nxt;

    // Writes keep only bits 31:7; lower bits are constants or the loaded placement type on read.
    // Bits 6:0 are never stored, so a write there cannot disturb the
    // fixed flag and zero bits that reads rebuild from constants.
    // Writes to the subsystem codes and to unmapped offsets are dropped.
    always_comb
    begin
        io_window_field_nxt = io_window_field_r;
        mem_window_field_nxt = mem_window_field_r;
        if (cfg_wr && cfg_addr == IO_OFS)
        begin
            io_window_field_nxt = cfg_wdata[31:`WINDOW_LSB];
        end
        if (cfg_wr && cfg_addr == MEM_OFS)
        begin
            mem_window_field_nxt = cfg_wdata[31:`WINDOW_LSB];
        end
    end

    // Registers the base fields.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            io_window_field_r <= `WINDOW_RESET;
            mem_window_field_r <= `WINDOW_RESET;
        end
        else
        begin
            io_window_field_r <= io_window_field_nxt;
            mem_window_field_r <= mem_window_field_nxt;
        end
    end

    // ------------------------------------------------------------------
    // EEPROM loader
    // ------------------------------------------------------------------
    load_state_e load_state_r;
    load_state_e load_state_nxt;
    logic place_low_r;
    logic place_low_nxt;
    logic [15:0] maker_code_r;
    logic [15:0] maker_code_nxt;
    logic [15:0] product_code_r;
    logic [15:0] product_code_nxt;
    logic ee_req_r;
    logic ee_req_nxt;
    logic [7:0] ee_addr_r;
    logic [7:0] ee_addr_nxt;
    logic ee_loaded_r;
    logic ee_loaded_nxt;

    // Walks the three words once after reset; request holds until ack.
    // The options word goes first so the placement type is ready early.
    always_comb
    begin
        load_state_nxt = load_state_r;
        place_low_nxt = place_low_r;
        maker_code_nxt = maker_code_r;
        product_code_nxt = product_code_r;
        ee_req_nxt = ee_req_r;
        ee_addr_nxt = ee_addr_r;
        ee_loaded_nxt = ee_loaded_r;
        case (load_state_r)
            LOAD_OPTIONS:
            begin
                ee_req_nxt = 1'h1;
                ee_addr_nxt = `EE_OPTIONS_WORD;
                if (ee_req_r && ee_ack)
                begin
                    place_low_nxt = ee_data[`OPT_PLACE_BIT];
                    ee_addr_nxt = `EE_MAKER_WORD;
                    load_state_nxt = LOAD_MAKER;
                end
            end
            LOAD_MAKER:
            begin
                if (ee_ack)
                begin
                    maker_code_nxt = ee_data;
                    ee_addr_nxt = `EE_PRODUCT_WORD;
                    load_state_nxt = LOAD_PRODUCT;
                end
            end
            LOAD_PRODUCT:
            begin
                if (ee_ack)
                begin
                    product_code_nxt = ee_data;
                    ee_req_nxt = 1'h0;
                    ee_loaded_nxt = 1'h1;
                    load_state_nxt = LOAD_DONE;
                end
            end
            LOAD_DONE:
            begin
                // Acknowledges that arrive after loading are ignored.
                ee_req_nxt = 1'h0;
            end
            default:
            begin
                load_state_nxt = LOAD_OPTIONS;
            end
        endcase
    end

    // Registers the loader state.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            load_state_r <= LOAD_OPTIONS;
            place_low_r <= 1'h0;
            maker_code_r <= `CODE_RESET;
            product_code_r <= `CODE_RESET;
            ee_req_r <= 1'h0;
            ee_addr_r <= 8'h00;
            ee_loaded_r <= 1'h0;
        end
        else
        begin
            load_state_r <= load_state_nxt;
            place_low_r <= place_low_nxt;
            maker_code_r <= maker_code_nxt;
            product_code_r <= product_code_nxt;
            ee_req_r <= ee_req_nxt;
            ee_addr_r <= ee_addr_nxt;
            ee_loaded_r <= ee_loaded_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [31:0] io_base_view;
    logic [31:0] mem_base_view;
    logic [1:0] place_type;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Assembles the full 32-bit views of both base registers.
    assign io_base_view = {io_window_field_r,
                           5'h00,
                           1'h0,
                           `IO_KIND_FLAG_VAL};
    assign place_type = place_low_r ? `PLACE_BELOW_1MB
                                    : `PLACE_ANY_32;
    assign mem_base_view = {mem_window_field_r,
                            3'h0,
                            `PREFETCH_VAL,
                            place_type,
                            `MEM_KIND_FLAG_VAL};

    // Selects read data; unmapped offsets read zero, data is one cycle late.
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (cfg_rd)
        begin
            case (cfg_addr)
                IO_OFS: rdata_nxt = io_base_view;
                MEM_OFS: rdata_nxt = mem_base_view;
                MAKER_OFS: rdata_nxt = {16'h0000, maker_code_r};
                PROD_OFS: rdata_nxt = {16'h0000, product_code_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Registers read data.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r <= 32'h00000000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------------
    win_claim_s claim_r;
    win_claim_s claim_nxt;
    logic io_match;
    logic mem_match;

    // Both bases reset to zero, so addresses 0 to 7fh hit either window
    // until the host programs the bases.
    // Compares the upper 25 address bits with the selected base.
    assign io_match = win_req.addr[31:`WINDOW_LSB] == io_window_field_r;
    assign mem_match = win_req.addr[31:`WINDOW_LSB] == mem_window_field_r;

    // Claims a hit in either space with the same register offset.
    always_comb
    begin
        claim_nxt.hit = 1'h0;
        claim_nxt.is_io = win_req.is_io;
        claim_nxt.offset = win_req.addr[6:0];
        if (win_req.valid)
        begin
            claim_nxt.hit = win_req.is_io ? io_match
                                          : mem_match;
        end
    end

    // Registers the decode answer.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            claim_r <= '0;
        end
        else
        begin
            claim_r <= claim_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is driven straight from a register.
    assign cfg_rdata = rdata_r;
    assign ee_req = ee_req_r;
    assign ee_addr = ee_addr_r;
    assign ee_loaded = ee_loaded_r;
    assign win_claim = claim_r;

endmodule : pci_window_base_and_subsystem_regs

// [tb/pci_window_checker.sv]
// Port-level assertions for the window register block.
`timescale 1ns/1ns
`include "pci_window_defs.svh"
module pci_window_checker
    import pci_window_pkg::*;
#(
    parameter int CFG_AW = 8
)
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [CFG_AW-1:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_rdata,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    input wire logic ee_ack,
    input wire logic ee_loaded,
    input wire win_req_s win_req,
    input wire win_claim_s win_claim
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic io_a;
    logic mem_a;
    logic ack_a;
    // Offset matches and taken loader words.
    assign io_a = cfg_addr == CFG_AW'(`IO_WINDOW_BASE_OFS);
    assign mem_a = cfg_addr == CFG_AW'(`MEM_WINDOW_BASE_OFS);
    assign ack_a = ee_req && ee_ack;
    a_io_fixed_bits:
        assert property (cfg_rd && io_a |=> cfg_rdata[6:0] == 7'h01)
        else $error("io base low bits wrong");
    a_mem_fixed_bits:
        assert property (cfg_rd && mem_a |=> cfg_rdata[6:2] == 5'h0 &&
            !cfg_rdata[0]) else $error("mem base low bits wrong");
    a_io_write_back:
        assert property (cfg_wr && io_a ##2 cfg_rd && io_a |=>
            cfg_rdata[31:7] == $past(cfg_wdata[31:7], 3))
        else $error("io base field not stored");
    a_claim_idle:
        assert property (!win_req.valid |=> !win_claim.hit)
        else $error("claim without request");
    a_claim_offset:
        assert property (win_req.valid |=> !win_claim.hit ||
            win_claim.offset == $past(win_req.addr[6:0]))
        else $error("claim offset wrong");
    a_ee_maker_next:
        assert property (ack_a && ee_addr == `EE_OPTIONS_WORD |=>
            ee_req && ee_addr == `EE_MAKER_WORD) else $error("no maker load");
    a_ee_product_next:
        assert property (ack_a && ee_addr == `EE_MAKER_WORD |=>
            ee_req && ee_addr == `EE_PRODUCT_WORD) else $error("no product");
    a_ee_load_done:
        assert property (ack_a && ee_addr == `EE_PRODUCT_WORD |=>
            !ee_req && ee_loaded) else $error("load not finished");
    c_write_read: cover property (cfg_wr && io_a ##2 cfg_rd && io_a);
    c_hit: cover property (win_claim.hit);
    c_low_place: cover property (cfg_rd && mem_a ##1 cfg_rdata[1]);
endmodule : pci_window_checker

bind pci_window_base_and_subsystem_regs pci_window_checker #(
    .CFG_AW(CFG_AW)
) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .ee_req(ee_req), .ee_addr(ee_addr),
    .ee_ack(ee_ack), .ee_loaded(ee_loaded), .win_req(win_req),
    .win_claim(win_claim)
);

// [tb/eeprom_word_model.sv]
// Behavioural EEPROM word source for the loader port.
`timescale 1ns/1ns
module eeprom_word_model
(
    // Clock, reset and word port
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    output logic ee_ack,
    output logic [15:0] ee_data,
    // Stored words and reply delay
    input wire logic [15:0] opt_w,
    input wire logic [15:0] maker_w,
    input wire logic [15:0] prod_w,
    input wire logic [2:0] wait_c
);
    logic [2:0] cnt;
    // Replies after wait_c cycles; data toggles outside a reply.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ee_ack <= 1'b0;
            cnt <= 3'h0;
            ee_data <= 16'h5a5a;
        end
        else if (ee_req && !ee_ack && cnt == wait_c)
        begin
            ee_ack <= 1'b1;
            cnt <= 3'h0;
            ee_data <= (ee_addr == 8'h17) ? maker_w :
                (ee_addr == 8'h18) ? prod_w : opt_w;
        end
        else
        begin
            ee_ack <= 1'b0;
            cnt <= (ee_req && !ee_ack) ? cnt + 3'h1 : 3'h0;
            ee_data <= ~ee_data;
        end
    end
endmodule : eeprom_word_model

// [tb/test_pci_window_base_and_subsystem_regs.sv]
// Self-checking bench for the window register block.
`timescale 1ns/1ns
module test_pci_window_base_and_subsystem_regs
    import pci_window_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] cfg_addr = 8'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [31:0] cfg_rdata, io_m, mem_m, v, r, x;
    logic ee_req, ee_ack, ee_loaded;
    logic [7:0] ee_addr;
    logic [15:0] ee_data;
    logic [15:0] opt_w = 16'h0, maker_w = 16'h0, prod_w = 16'h0;
    logic [2:0] wait_c = 3'h0;
    win_req_s win_req = '0;
    win_claim_s win_claim;
    int num_errors = 0;
    int checked = 0;
    int k;
    always #2 sys_clk = ~sys_clk;
    pci_window_base_and_subsystem_regs DUT (.sys_clk(sys_clk),
        .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack),
        .ee_data(ee_data), .ee_loaded(ee_loaded), .win_req(win_req),
        .win_claim(win_claim));
    eeprom_word_model u_ee (.sys_clk(sys_clk), .rst_b(rst_b),
        .ee_req(ee_req), .ee_addr(ee_addr), .ee_ack(ee_ack),
        .ee_data(ee_data), .opt_w(opt_w), .maker_w(maker_w),
        .prod_w(prod_w), .wait_c(wait_c));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        #1 d = cfg_rdata;
    endtask : rd
    // One decode request; the claim is judged against the model bases.
    task automatic dec(logic io, logic [31:0] a);
        logic h;
        h = a[31:7] == (io ? io_m[31:7] : mem_m[31:7]);
        @(posedge sys_clk);
        win_req <= '{1'b1, io, a};
        @(posedge sys_clk);
        win_req.valid <= 1'b0;
        #1 check("hit", 32'(win_claim.hit), 32'(h));
        if (h)
            check("offset", 32'(win_claim.offset), 32'(a[6:0]));
        check("is_io", 32'(win_claim.is_io), 32'(io));
    endtask : dec
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Two resets: prompt EEPROM with type 00b, slow one with type 01b.
    initial
    begin
        void'($urandom(67507));
        for (int p = 0; p < 2; p++)
        begin
            v = $urandom();
            opt_w <= {v[15:3], p[0], v[1:0]};
            maker_w <= v[31:16];
            prod_w <= 16'($urandom());
            wait_c <= p[0] ? 3'h7 : 3'h0;
            rst_b <= 1'b0;
            repeat (6) @(posedge sys_clk);
            rst_b <= 1'b1;
            io_m = 32'h0;
            mem_m = 32'h0;
            rd(8'h2c, r);
            check("early code", r, 32'h0);
            check("early load", 32'(ee_loaded), 32'h0);
            for (k = 0; k < 200 && ee_loaded !== 1'b1; k++)
                @(posedge sys_clk);
            check("loaded", 32'(ee_loaded), 32'h1);
            rd(8'h2c, r);
            check("maker", r, {16'h0, maker_w});
            wr(8'h2e, 32'hffffffff);
            rd(8'h2e, r);
            check("product", r, {16'h0, prod_w});
            rd(8'h20, r);
            check("unmapped", r, 32'h0);
            for (k = 0; k < 6; k++)
            begin
                rd(8'h10, r);
                check("io", r, {io_m[31:7], 7'h01});
                rd(8'h14, r);
                x = {mem_m[31:7], 5'h0, opt_w[2], 1'b0};
                check("mem", r, x);
                v = (k == 0) ? 32'hffffffff : $urandom();
                wr(8'h10, v);
                io_m = v;
                rd(8'h10, r);
                check("io back", r, {io_m[31:7], 7'h01});
                v = (k == 0) ? 32'hffffffff : $urandom();
                wr(8'h14, v);
                mem_m = v;
                rd(8'h14, r);
                x = {mem_m[31:7], 5'h0, opt_w[2], 1'b0};
                check("mem back", r, x);
                dec(1'b1, {io_m[31:7], 7'h7f});
                dec(1'b1, {io_m[31:7], 7'h0} + 32'h80);
                dec(1'b0, {mem_m[31:7], 7'($urandom())});
                dec(1'b0, {io_m[31:7], 7'h05});
            end
        end
        print_verdict;
    end
    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        print_verdict;
    end
endmodule : test_pci_window_base_and_subsystem_regs
